// ### sdll_pkg.sv
// Shared constants for the serial converter load logic and its host end
package sdll_pkg;

    // Converter code width and fixed values
    localparam int                CODE_W        = 12;
    localparam logic [CODE_W-1:0] CODE_ZERO     = 12'h000;
    localparam logic [CODE_W-1:0] CODE_FULL     = 12'hfff;
    localparam int                MV_PER_LSB    = 1;
    localparam int                FULL_SCALE_MV = 4095;

    // Bit counter in the device, saturating one past a full word
    localparam int                BIT_CNT_W     = 4;
    localparam logic [3:0]        BITS_PER_WORD = 4'hc;
    localparam logic [3:0]        BIT_CNT_MAX   = 4'hd;
    localparam logic [3:0]        BIT_CNT_ZERO  = 4'h0;
    localparam logic [3:0]        BIT_CNT_ONE   = 4'h1;
    localparam logic [3:0]        MSB_INDEX     = 4'hb;

    // Reference clock and host timing, times in ns
    localparam int REF_CLK_PERIOD_NS = 25;
    localparam int LINK_HALF_NS      = 50;
    localparam int LOAD_PULSE_NS     = 200;
    localparam int CLEAR_PULSE_NS    = 200;
    localparam int GAP_NS            = 200;

    // Least times round up to whole reference cycles
    localparam int LINK_HALF_CYC   = (LINK_HALF_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
    localparam int LOAD_PULSE_CYC  = (LOAD_PULSE_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
    localparam int CLEAR_PULSE_CYC = (CLEAR_PULSE_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
    localparam int GAP_CYC         = (GAP_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;

    // Host down-counter width and reload values
    localparam int             TMR_W      = 4;
    localparam logic [TMR_W-1:0] TMR_ZERO   = 4'h0;
    localparam logic [TMR_W-1:0] HALF_LOAD  = TMR_W'(LINK_HALF_CYC - 1);
    localparam logic [TMR_W-1:0] LOAD_LOAD  = TMR_W'(LOAD_PULSE_CYC - 1);
    localparam logic [TMR_W-1:0] CLEAR_LOAD = TMR_W'(CLEAR_PULSE_CYC - 1);
    localparam logic [TMR_W-1:0] GAP_LOAD   = TMR_W'(GAP_CYC - 1);

    // Host sequencer states
    typedef enum logic [2:0] {
        SDLL_H_IDLE,
        SDLL_H_SHIFT_LO,
        SDLL_H_SHIFT_HI,
        SDLL_H_LOAD,
        SDLL_H_CLEAR,
        SDLL_H_GAP
    } sdll_host_state_t;

endpackage : sdll_pkg

// ### sdll_link_if.sv
// Serial link between the host end and the converter end
`timescale 1ns/1ps
interface sdll_link_if;
    logic link_clk;       // Serial shift clock, made by the host
    logic select_n;       // Device select, active low
    logic serial_in;      // Serial data, MSB first
    logic load_strobe_n;  // Load strobe, active low, level sensitive
    logic clear_n;        // Clear, active low, asynchronous

    // Host drives every wire
    modport host (
        output link_clk,
        output select_n,
        output serial_in,
        output load_strobe_n,
        output clear_n
    );

    // Converter end only listens
    modport dev (
        input link_clk,
        input select_n,
        input serial_in,
        input load_strobe_n,
        input clear_n
    );
endinterface : sdll_link_if

// ### sdll_sync3.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module sdll_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_i,  // Destination clock
    input  wire logic rst_i,  // Synchronous reset, active high
    input  wire logic d_i,    // Level from another domain
    output logic      q_o     // Filtered level
);
    logic s1_r, s2_r, s3_r, q_r;
    logic s1_nxt, s2_nxt, s3_nxt, q_nxt;

    // Shift chain; output moves only when last two stages agree
    always_comb begin
        s1_nxt = d_i;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        q_nxt  = (s2_r == s3_r) ? s3_r : q_r;
    end

    // Stage registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            q_r  <= RST_VAL;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            q_r  <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule : sdll_sync3

// ### sdll_dev.sv
// Converter end: serial input register, load and clear of the converter code
`timescale 1ns/1ps
module sdll_dev
    import sdll_pkg::*;
(
    input  wire logic                      ref_clk_i,     // 40 MHz converter clock
    input  wire logic                      sys_rst_i,     // Synchronous reset, active high
    sdll_link_if.dev                       link,          // Serial link from the host
    output logic [sdll_pkg::CODE_W-1:0]    code_o,        // Converter code, 1 mV per step
    output logic                           word_ready_o,  // Twelve or more bits since load
    output logic                           overrun_o,     // More than twelve bits since load
    output logic                           load_err_o     // Shifting seen while strobe low
);
    import sdll_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: serial input register
    ////////////////////////////////////////////////////////////////////////////

    logic [CODE_W-1:0] shift_r;
    logic [CODE_W-1:0] shift_nxt;
    logic              shift_tgl_r;
    logic              shift_tgl_nxt;
    logic              shift_en;

    // Advance only while selected; a select edge with clock low gives no link edge
    assign shift_en = ~link.select_n;

    // Next shift word, MSB enters first and walks upward
    always_comb begin
        shift_nxt     = shift_r;
        shift_tgl_nxt = shift_tgl_r;
        if (shift_en) begin
            shift_nxt     = {shift_r[CODE_W-2:0], link.serial_in};
            shift_tgl_nxt = ~shift_tgl_r;
        end
    end

    // Data word holds its bits; clear does not touch it
    always_ff @(posedge link.link_clk) begin
        shift_r <= shift_nxt;
    end

    // Event toggle, cleared to a constant by the clear pin
    always_ff @(posedge link.link_clk or negedge link.clear_n) begin
        if (!link.clear_n) begin
            shift_tgl_r <= 1'b0;
        end else begin
            shift_tgl_r <= shift_tgl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crossings into the reference domain
    ////////////////////////////////////////////////////////////////////////////

    logic ld_n_s;
    logic clr_n_s;
    logic tgl_s;

    // Load strobe level
    sdll_sync3 #(
        .RST_VAL (1'b1)
    ) u_sync_load (
        .clk_i (ref_clk_i),
        .rst_i (sys_rst_i),
        .d_i   (link.load_strobe_n),
        .q_o   (ld_n_s)
    );

    // Clear level, used for release and bookkeeping
    sdll_sync3 #(
        .RST_VAL (1'b0)
    ) u_sync_clear (
        .clk_i (ref_clk_i),
        .rst_i (sys_rst_i),
        .d_i   (link.clear_n),
        .q_o   (clr_n_s)
    );

    // Shift event toggle
    sdll_sync3 #(
        .RST_VAL (1'b0)
    ) u_sync_tgl (
        .clk_i (ref_clk_i),
        .rst_i (sys_rst_i),
        .d_i   (shift_tgl_r),
        .q_o   (tgl_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Reference domain: bit bookkeeping
    ////////////////////////////////////////////////////////////////////////////

    logic                 tgl_seen_r;
    logic                 tgl_seen_nxt;
    logic [BIT_CNT_W-1:0] bit_cnt_r;
    logic [BIT_CNT_W-1:0] bit_cnt_nxt;
    logic                 word_ready_r;
    logic                 word_ready_nxt;
    logic                 overrun_r;
    logic                 overrun_nxt;
    logic                 load_err_r;
    logic                 load_err_nxt;
    logic                 shift_evt;
    logic                 load_act;

    // One shift event per toggle change, ignored while clear is low
    assign shift_evt = (tgl_s != tgl_seen_r) && clr_n_s;
    // Load acts only with clear released
    assign load_act  = ~ld_n_s && clr_n_s;

    // Count bits since the last load, saturating past a word
    always_comb begin
        tgl_seen_nxt = tgl_s;
        bit_cnt_nxt  = bit_cnt_r;
        if (load_act) begin
            bit_cnt_nxt = BIT_CNT_ZERO;
        end else if (shift_evt && (bit_cnt_r != BIT_CNT_MAX)) begin
            bit_cnt_nxt = bit_cnt_r + BIT_CNT_ONE;
        end
        word_ready_nxt = (bit_cnt_nxt >= BITS_PER_WORD);
        overrun_nxt    = (bit_cnt_nxt > BITS_PER_WORD);
        // Sticky; a new event wins over nothing, only reset clears it
        load_err_nxt   = load_err_r || (shift_evt && ~ld_n_s);
    end

    // Bookkeeping registers
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            tgl_seen_r   <= 1'b0;
            bit_cnt_r    <= BIT_CNT_ZERO;
            word_ready_r <= 1'b0;
            overrun_r    <= 1'b0;
            load_err_r   <= 1'b0;
        end else begin
            tgl_seen_r   <= tgl_seen_nxt;
            bit_cnt_r    <= bit_cnt_nxt;
            word_ready_r <= word_ready_nxt;
            overrun_r    <= overrun_nxt;
            load_err_r   <= load_err_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference domain: converter code register
    ////////////////////////////////////////////////////////////////////////////

    logic [CODE_W-1:0] code_r;
    logic [CODE_W-1:0] code_nxt;

    // Transparent while strobe low; the shift word is quiet then, so it is taken whole
    always_comb begin
        code_nxt = code_r;
        if (load_act) begin
            code_nxt = shift_r;
        end
    end

    // Clear pin resets at once; clear release stays zero until sync sees it
    always_ff @(posedge ref_clk_i or negedge link.clear_n) begin
        if (!link.clear_n) begin
            code_r <= CODE_ZERO;
        end else if (sys_rst_i) begin
            code_r <= CODE_ZERO;
        end else begin
            code_r <= code_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////////

    // Code in millivolts equals the code itself
    assign code_o       = code_r;
    assign word_ready_o = word_ready_r;
    assign overrun_o    = overrun_r;
    assign load_err_o   = load_err_r;

endmodule : sdll_dev

// ### sdll_host.sv
// Host end: sends a 12-bit word, pulses the load strobe, pulses clear on request
`timescale 1ns/1ps
module sdll_host
    import sdll_pkg::*;
(
    input  wire logic                   ref_clk_i,     // 40 MHz host clock
    input  wire logic                   sys_rst_i,     // Synchronous reset, active high
    input  wire logic                   write_i,       // Pulse: send and load a word
    input  wire logic [sdll_pkg::CODE_W-1:0] write_data_i, // Word taken with write_i
    input  wire logic                   clear_i,       // Pulse: clear the converter
    output logic                        busy_o,        // Sequence in progress
    output logic                        done_o,        // Pulse: sequence finished
    sdll_link_if.host                   link           // Serial link to the device
);
    import sdll_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state
    ////////////////////////////////////////////////////////////////////////////

    sdll_host_state_t      state_r, state_nxt;
    logic [TMR_W-1:0]      tmr_r, tmr_nxt;
    logic [BIT_CNT_W-1:0]  bit_r, bit_nxt;
    logic [CODE_W-1:0]     word_r, word_nxt;
    logic                  clk_r, clk_nxt;
    logic                  sel_n_r, sel_n_nxt;
    logic                  sdo_r, sdo_nxt;
    logic                  ld_n_r, ld_n_nxt;
    logic                  clr_n_r, clr_n_nxt;
    logic                  busy_r, busy_nxt;
    logic                  done_r, done_nxt;
    logic                  tmr_end;

    assign tmr_end = (tmr_r == TMR_ZERO);

    // Next-state logic; link clock made by dividing the host clock
    always_comb begin
        state_nxt = state_r;
        tmr_nxt   = tmr_end ? TMR_ZERO : tmr_r - 4'h1;
        bit_nxt   = bit_r;
        word_nxt  = word_r;
        clk_nxt   = clk_r;
        sel_n_nxt = sel_n_r;
        sdo_nxt   = sdo_r;
        ld_n_nxt  = ld_n_r;
        clr_n_nxt = clr_n_r;
        done_nxt  = 1'b0;
        case (state_r)
            SDLL_H_IDLE: begin
                clr_n_nxt = 1'b1;  // Release the power-on clear
                if (clear_i) begin
                    clr_n_nxt = 1'b0;
                    tmr_nxt   = CLEAR_LOAD;
                    state_nxt = SDLL_H_CLEAR;
                end else if (write_i) begin
                    word_nxt  = write_data_i;
                    sel_n_nxt = 1'b0;
                    sdo_nxt   = write_data_i[MSB_INDEX];
                    bit_nxt   = MSB_INDEX;
                    tmr_nxt   = HALF_LOAD;
                    state_nxt = SDLL_H_SHIFT_LO;
                end
            end
            SDLL_H_SHIFT_LO: begin
                if (tmr_end) begin
                    clk_nxt   = 1'b1;
                    tmr_nxt   = HALF_LOAD;
                    state_nxt = SDLL_H_SHIFT_HI;
                end
            end
            SDLL_H_SHIFT_HI: begin
                if (tmr_end) begin
                    clk_nxt = 1'b0;
                    tmr_nxt = HALF_LOAD;
                    if (bit_r == BIT_CNT_ZERO) begin
                        sel_n_nxt = 1'b1;
                        ld_n_nxt  = 1'b0;
                        tmr_nxt   = LOAD_LOAD;
                        state_nxt = SDLL_H_LOAD;
                    end else begin
                        bit_nxt   = bit_r - BIT_CNT_ONE;
                        sdo_nxt   = word_r[bit_r - BIT_CNT_ONE];
                        state_nxt = SDLL_H_SHIFT_LO;
                    end
                end
            end
            SDLL_H_LOAD: begin
                if (tmr_end) begin
                    ld_n_nxt  = 1'b1;
                    tmr_nxt   = GAP_LOAD;
                    state_nxt = SDLL_H_GAP;
                end
            end
            SDLL_H_CLEAR: begin
                if (tmr_end) begin
                    clr_n_nxt = 1'b1;
                    tmr_nxt   = GAP_LOAD;
                    state_nxt = SDLL_H_GAP;
                end
            end
            SDLL_H_GAP: begin
                if (tmr_end) begin
                    done_nxt  = 1'b1;
                    state_nxt = SDLL_H_IDLE;
                end
            end
            default: begin
                state_nxt = SDLL_H_IDLE;
            end
        endcase
        busy_nxt = (state_nxt != SDLL_H_IDLE);
    end

    // Sequencer registers; clear held low in reset so the far end starts known
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_r <= SDLL_H_IDLE;
            tmr_r   <= TMR_ZERO;
            bit_r   <= BIT_CNT_ZERO;
            word_r  <= CODE_ZERO;
            clk_r   <= 1'b0;
            sel_n_r <= 1'b1;
            sdo_r   <= 1'b0;
            ld_n_r  <= 1'b1;
            clr_n_r <= 1'b0;
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            tmr_r   <= tmr_nxt;
            bit_r   <= bit_nxt;
            word_r  <= word_nxt;
            clk_r   <= clk_nxt;
            sel_n_r <= sel_n_nxt;
            sdo_r   <= sdo_nxt;
            ld_n_r  <= ld_n_nxt;
            clr_n_r <= clr_n_nxt;
            busy_r  <= busy_nxt;
            done_r  <= done_nxt;
        end
    end

    // Link and status outputs straight from flops
    assign link.link_clk      = clk_r;
    assign link.select_n      = sel_n_r;
    assign link.serial_in     = sdo_r;
    assign link.load_strobe_n = ld_n_r;
    assign link.clear_n       = clr_n_r;
    assign busy_o             = busy_r;
    assign done_o             = done_r;

endmodule : sdll_host

// ### sdll_assertions.sv
// Checker for the serial link and the converter code
`timescale 1ns/1ps
module sdll_assertions
    import sdll_pkg::*;
(
    input  wire logic                      ref_clk_i,     // Reference clock
    input  wire logic                      sys_rst_i,     // Reset, active high
    input  wire logic                      link_clk,      // Serial clock
    input  wire logic                      select_n,      // Select, active low
    input  wire logic                      serial_in,     // Serial data
    input  wire logic                      load_strobe_n, // Load strobe, active low
    input  wire logic                      clear_n,       // Clear, active low
    input  wire logic [sdll_pkg::CODE_W-1:0] code_o       // Converter code
);
    import sdll_pkg::*;

    logic              lc_r;
    logic              lc_nxt;
    logic [3:0]        cnt_r;
    logic [3:0]        cnt_nxt;
    logic [CODE_W-1:0] word_r;
    logic [CODE_W-1:0] word_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Rebuild the shifted word and its bit count
    always_comb begin
        lc_nxt   = link_clk;
        cnt_nxt  = cnt_r;
        word_nxt = word_r;
        if (sys_rst_i || !load_strobe_n) begin
            cnt_nxt = 4'h0;
        end else if (link_clk && !lc_r && !select_n) begin
            cnt_nxt  = cnt_r + 4'h1;
            word_nxt = {word_r[CODE_W-2:0], serial_in};
        end
    end

    // Register the helper state
    always_ff @(posedge ref_clk_i) begin
        lc_r   <= lc_nxt;
        cnt_r  <= cnt_nxt;
        word_r <= word_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Properties, all on the reference clock
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    clear_forces_zero_a : assert property (!clear_n |-> code_o == CODE_ZERO)
        else $error("code not zero while clear low");
    clear_release_zero_a : assert property ($rose(clear_n) |-> (code_o == CODE_ZERO)[*3])
        else $error("code left zero after clear release");
    clock_when_selected_a : assert property ($rose(link_clk) |-> !select_n)
        else $error("link clock rose while not selected");
    data_stable_high_a : assert property (link_clk |-> $stable(serial_in))
        else $error("serial data moved while clock high");
    word_complete_a : assert property ($fell(load_strobe_n) |-> cnt_r == BITS_PER_WORD)
        else $error("load before a full word");
    quiet_during_load_a : assert property (!load_strobe_n |-> select_n && !link_clk)
        else $error("shifting while strobe low");
    load_copies_word_a : assert property ($fell(load_strobe_n) && clear_n |->
        ##[3:7] code_o == word_r)
        else $error("code did not take shifted word");
    code_holds_shift_a : assert property (!select_n && !$past(select_n) |->
        $stable(code_o))
        else $error("code moved while shifting");
endmodule : sdll_assertions

// ### test_serial_dac_load_logic.sv
// Self-checking bench for both ends of the serial converter link
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_serial_dac_load_logic;
    import sdll_pkg::*;
    logic              ref_clk_i    = 1'b0;
    logic              sys_rst_i    = 1'b1;
    logic              write_i      = 1'b0;
    logic [CODE_W-1:0] write_data_i = 12'h000;
    logic              clear_i      = 1'b0;
    logic              busy_o;
    logic              done_o;
    logic [CODE_W-1:0] code_o;
    logic              word_ready_o;
    logic              overrun_o;
    logic              load_err_o;
    logic [CODE_W-1:0] code_b;
    logic              ready_b;
    logic              over_b;
    logic              err_b;
    logic [CODE_W-1:0] vals [5] = '{12'hfff, 12'h800, 12'h7ff, 12'h801, 12'h000};
    int                failures;
    int                samples_checked;

    sdll_link_if lnk ();
    sdll_link_if lnk2 ();

    ////////////////////////////////////////////////////////////////////////////////
    // Host and device face each other; a second device is driven by hand
    sdll_host u_sdll_host (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .write_i(write_i),
        .write_data_i(write_data_i), .clear_i(clear_i), .busy_o(busy_o), .done_o(done_o),
        .link(lnk.host));
    sdll_dev u_sdll_dev (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .link(lnk.dev),
        .code_o(code_o), .word_ready_o(word_ready_o), .overrun_o(overrun_o),
        .load_err_o(load_err_o));
    sdll_dev u_sdll_dev_2 (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .link(lnk2.dev),
        .code_o(code_b), .word_ready_o(ready_b), .overrun_o(over_b), .load_err_o(err_b));
    sdll_assertions u_sdll_assertions (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .link_clk(lnk.link_clk), .select_n(lnk.select_n), .serial_in(lnk.serial_in),
        .load_strobe_n(lnk.load_strobe_n), .clear_n(lnk.clear_n), .code_o(code_o));

    // Reference clock, 25 ns
    always #12.5 ref_clk_i = ~ref_clk_i;

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic results();
        if (failures == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // Wait for the host sequence to end, bounded
    task automatic wait_done();
        int n;
        n = 0;
        while (done_o !== 1'b1) begin
            @(posedge ref_clk_i);
            n++;
            if (n > 200) begin
                failures++;
                results();
            end
        end
    endtask : wait_done

    // One host request, then wait for its end
    task automatic host_op(input logic wr, input logic cl, input logic [CODE_W-1:0] d);
        write_i      <= wr;
        clear_i      <= cl;
        write_data_i <= d;
        @(posedge ref_clk_i);
        write_i <= 1'b0;
        clear_i <= 1'b0;
        @(posedge ref_clk_i);
        wait_done();
    endtask : host_op

    // Shift n bits MSB first into the second device, two cycles per phase
    task automatic shift_b(input logic [15:0] v, input int n, input logic sel_n);
        lnk2.select_n <= sel_n;
        for (int i = n - 1; i >= 0; i--) begin
            lnk2.serial_in <= v[i];
            repeat (2) @(posedge ref_clk_i);
            lnk2.link_clk <= 1'b1;
            repeat (2) @(posedge ref_clk_i);
            lnk2.link_clk <= 1'b0;
        end
        repeat (2) @(posedge ref_clk_i);
        lnk2.select_n  <= 1'b1;
        lnk2.serial_in <= ~lnk2.serial_in;  // Released line shows no stale bit
        repeat (8) @(posedge ref_clk_i);  // Bit count crosses over
    endtask : shift_b

    // Strobe the second device's load for eight cycles
    task automatic load_b();
        lnk2.load_strobe_n <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        lnk2.load_strobe_n <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
    endtask : load_b

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        lnk2.link_clk      <= 1'b0;
        lnk2.select_n      <= 1'b1;
        lnk2.serial_in     <= 1'b0;
        lnk2.load_strobe_n <= 1'b1;
        lnk2.clear_n       <= 1'b0;
        repeat (12) @(posedge ref_clk_i);
        sys_rst_i    <= 1'b0;
        lnk2.clear_n <= 1'b1;
        @(posedge ref_clk_i);
        `CHK(code_o, CODE_ZERO)
        `CHK(busy_o, 1'b0)
        // Words through the real host, boundary codes included
        foreach (vals[i]) begin
            host_op(1'b1, 1'b0, vals[i]);
            `CHK(code_o, vals[i])
            `CHK(word_ready_o, 1'b0)
            `CHK(overrun_o, 1'b0)
        end
        host_op(1'b1, 1'b0, 12'ha5c);
        host_op(1'b0, 1'b1, 12'h000);
        `CHK(code_o, CODE_ZERO)
        // A clear request while busy is ignored
        write_i      <= 1'b1;
        write_data_i <= 12'h5a5;
        @(posedge ref_clk_i);
        write_i <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        clear_i <= 1'b1;
        @(posedge ref_clk_i);
        clear_i <= 1'b0;
        wait_done();
        `CHK(code_o, 12'h5a5)
        // Clear wins when both arrive together
        host_op(1'b1, 1'b1, 12'h3c3);
        `CHK(code_o, CODE_ZERO)
        `CHK(load_err_o, 1'b0)
        // Second device: clocks without select, then too many bits
        shift_b(16'hffff, 3, 1'b1);
        shift_b(16'h3abc, 14, 1'b0);
        `CHK(over_b, 1'b1)
        `CHK(ready_b, 1'b1)
        load_b();
        `CHK(code_b, 12'habc)
        `CHK(ready_b, 1'b0)
        shift_b(16'h0123, 12, 1'b0);
        `CHK(code_b, 12'habc)
        load_b();
        `CHK(code_b, 12'h123)
        `CHK(over_b, 1'b0)
        // Clear acts at once and holds zero after release
        lnk2.clear_n <= 1'b0;
        @(posedge ref_clk_i);
        `CHK(code_b, CODE_ZERO)
        repeat (7) @(posedge ref_clk_i);
        lnk2.clear_n <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        `CHK(code_b, CODE_ZERO)
        // Shifting while the strobe is low is flagged
        `CHK(err_b, 1'b0)
        lnk2.load_strobe_n <= 1'b0;
        shift_b(16'h0001, 1, 1'b0);
        lnk2.load_strobe_n <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        `CHK(err_b, 1'b1)
        results();
    end
endmodule : test_serial_dac_load_logic
